/* core/chan_sub.sv */
// subscription match: one task listening on one event channel
// assumes channel pulses come from logic on the same clock
module chan_sub #(
	parameter int NCH = 16,
	parameter int CHW = 4
) (
	input wire logic en,
	input wire logic [CHW-1:0] idx,
	input wire logic [NCH-1:0] chan_in,
	output logic hit
);
	assign hit = en & chan_in[idx];
endmodule

/* core/evt_pub.sv */
// publish route: one event driven onto one event channel
// assumes the caller merges the vectors of all events
module evt_pub #(
	parameter int NCH = 16,
	parameter int CHW = 4
) (
	input wire logic en,
	input wire logic [CHW-1:0] idx,
	input wire logic fire,
	output logic [NCH-1:0] chan
);
	always_comb begin
		chan = '0;
		if (en & fire) begin
			chan[idx] = 1'b1;
		end
	end
endmodule

/* core/two_wire_slave_ctrl.sv */
// task, event, shortcut and channel layer of the two-wire slave, APB slave
// assumes the bus engine and the channel fabric run on pclk
//
// Contract
// - arm-receive task write arms write reception
// - arm-transmit task write arms read reply
// - halt task has channel subscription register
// - hold, continue, arm tasks have subscriptions
// - each event publishes on chosen channel
// - publish enable bit gates broadcasting
// - halted and fault event flags, publishable
// - receive and transmit begun flags, publishable
// - write and read command flags, publishable
// - shortcuts: command events trigger hold task
// - interrupt enable register, six bits, reset zero
// - enable-set register sets bits, reads state
// - halt completes, halted event, bus released
// - hold stretches clock until continue or halt task
//
// The APB register port was decided locally.
module two_wire_slave_ctrl
	import tws_pkg::*;
#(
	parameter int NCH = `NUM_CH,
	parameter int CHW = `CHANNEL_INDEX_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NCH-1:0] chan_in,
	output logic [NCH-1:0] chan_out,
	input wire logic eng_halted,
	input wire logic eng_error,
	input wire logic eng_rx_started,
	input wire logic eng_tx_started,
	input wire logic eng_write,
	input wire logic eng_read,
	output logic stop_req,
	output logic bus_release,
	output logic rx_armed,
	output logic tx_armed,
	output logic scl_hold,
	output logic irq
);
	localparam int NT = `NUM_TASK;
	localparam int NE = `NUM_EVT;

	typedef struct packed {
		ctrl_state_e st;
		route_cfg_s [NT-1:0] sub;
		route_cfg_s [NE-1:0] pub;
		logic [NE-1:0] flag;
		logic [NE-1:0] ien;
		logic [1:0] link;
		logic armed_rx;
		logic armed_tx;
		logic stop_p;
		logic release_p;
		logic [NCH-1:0] chan;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_s;

	state_s s_r;
	state_s s_nxt;
	logic [NT-1:0] sub_hit;
	logic [NCH-1:0] pub_chan [NE];
	logic [NE-1:0] ev;
	logic [NT-1:0] task_go;
	logic [NCH-1:0] chan_or;
	logic setup;
	logic acc;
	logic wr;
	logic hold_go;
	logic stop_done;
	logic [`ADDR_W-1:0] a;
	logic [32:0] rd;

	function automatic logic [`ADDR_W-1:0] task_ofs(input int i);
		case (i)
			0: task_ofs = `OFS_HALT_TASK;
			1: task_ofs = `OFS_HOLD_TASK;
			2: task_ofs = `OFS_CONT_TASK;
			3: task_ofs = `OFS_ARM_RX_TASK;
			default: task_ofs = `OFS_ARM_TX_TASK;
		endcase
	endfunction

	function automatic logic [`ADDR_W-1:0] sub_ofs(input int i);
		case (i)
			0: sub_ofs = `OFS_HALT_SUB;
			1: sub_ofs = `OFS_HOLD_SUB;
			2: sub_ofs = `OFS_CONT_SUB;
			3: sub_ofs = `OFS_ARM_RX_SUB;
			default: sub_ofs = `OFS_ARM_TX_SUB;
		endcase
	endfunction

	function automatic logic [`ADDR_W-1:0] evt_ofs(input int i);
		case (i)
			0: evt_ofs = `OFS_HALTED_EVT;
			1: evt_ofs = `OFS_FAULT_EVT;
			2: evt_ofs = `OFS_RX_BEGUN_EVT;
			3: evt_ofs = `OFS_TX_BEGUN_EVT;
			4: evt_ofs = `OFS_WRITE_EVT;
			default: evt_ofs = `OFS_READ_EVT;
		endcase
	endfunction

	function automatic logic [`ADDR_W-1:0] pub_ofs(input int i);
		case (i)
			0: pub_ofs = `OFS_HALTED_PUB;
			1: pub_ofs = `OFS_FAULT_PUB;
			2: pub_ofs = `OFS_RX_BEGUN_PUB;
			3: pub_ofs = `OFS_TX_BEGUN_PUB;
			4: pub_ofs = `OFS_WRITE_PUB;
			default: pub_ofs = `OFS_READ_PUB;
		endcase
	endfunction

	function automatic int evt_bit(input int i);
		case (i)
			0: evt_bit = `IEN_HALTED_BIT;
			1: evt_bit = `IEN_FAULT_BIT;
			2: evt_bit = `IEN_RX_BEGUN_BIT;
			3: evt_bit = `IEN_TX_BEGUN_BIT;
			4: evt_bit = `IEN_WRITE_BIT;
			default: evt_bit = `IEN_READ_BIT;
		endcase
	endfunction

	function automatic logic [NE-1:0] ev_unpack(input logic [31:0] d);
		ev_unpack = '0;
		for (int i = 0; i < NE; i++) begin
			ev_unpack[i] = d[evt_bit(i)];
		end
	endfunction

	function automatic logic [31:0] ev_pack(input logic [NE-1:0] v);
		ev_pack = `REG_RESET;
		for (int i = 0; i < NE; i++) begin
			ev_pack[evt_bit(i)] = v[i];
		end
	endfunction

	function automatic logic [31:0] route_pack(input route_cfg_s c);
		route_pack = `REG_RESET;
		route_pack[`ROUTE_EN_BIT] = c.en;
		route_pack[CHW-1:0] = c.idx;
	endfunction

	// bit 32 flags a mapped offset; write-only task registers read as zero
	function automatic logic [32:0] reg_read(input logic [`ADDR_W-1:0] ad, input state_s s);
		reg_read = {1'b0, `REG_RESET};
		for (int i = 0; i < NT; i++) begin
			if (ad == task_ofs(i)) begin
				reg_read = {1'b1, `REG_RESET};
			end
			if (ad == sub_ofs(i)) begin
				reg_read = {1'b1, route_pack(s.sub[i])};
			end
		end
		for (int i = 0; i < NE; i++) begin
			if (ad == evt_ofs(i)) begin
				reg_read = {1'b1, `REG_RESET};
				reg_read[`FLAG_BIT] = s.flag[i];
			end
			if (ad == pub_ofs(i)) begin
				reg_read = {1'b1, route_pack(s.pub[i])};
			end
		end
		if (ad == `OFS_LINKS) begin
			reg_read = {1'b1, `REG_RESET};
			reg_read[`LINK_WRITE_BIT] = s.link[0];
			reg_read[`LINK_READ_BIT] = s.link[1];
		end
		if (ad == `OFS_IEN || ad == `OFS_IEN_SET) begin
			reg_read = {1'b1, ev_pack(s.ien)};
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < NT; g++) begin : g_sub
			chan_sub #(.NCH(NCH), .CHW(CHW)) u_sub (
				.en(s_r.sub[g].en),
				.idx(s_r.sub[g].idx),
				.chan_in(chan_in),
				.hit(sub_hit[g])
			);
		end
		for (g = 0; g < NE; g++) begin : g_pub
			evt_pub #(.NCH(NCH), .CHW(CHW)) u_pub (
				.en(s_r.pub[g].en),
				.idx(s_r.pub[g].idx),
				.fire(ev[g]),
				.chan(pub_chan[g])
			);
		end
	endgenerate

	always_comb begin
		chan_or = '0;
		for (int i = 0; i < NE; i++) begin
			chan_or = chan_or | pub_chan[i];
		end
	end

	always_comb begin
		s_nxt = s_r;
		setup = psel & ~penable;
		acc = psel & penable & s_r.pready;
		wr = acc & pwrite;
		a = paddr[`ADDR_W-1:0];
		for (int i = 0; i < NT; i++) begin
			task_go[i] = (wr & (a == task_ofs(i)) & pwdata[`TASK_BIT]) | sub_hit[i];
		end
		hold_go = task_go[1] | (s_r.link[0] & eng_write) | (s_r.link[1] & eng_read);
		stop_done = (s_r.st == ST_STOPPING) & eng_halted;
		ev = {eng_read, eng_write, eng_tx_started, eng_rx_started, eng_error, stop_done};
		s_nxt.stop_p = 1'b0;
		s_nxt.release_p = stop_done;
		s_nxt.chan = chan_or;
		case (s_r.st)
			ST_IDLE: begin
				if (task_go[3] | task_go[4]) begin
					s_nxt.st = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (hold_go) begin
					s_nxt.st = ST_HELD;
				end
			end
			ST_HELD: begin
				if (task_go[2]) begin
					s_nxt.st = ST_ACTIVE;
				end
			end
			ST_STOPPING: begin
				if (eng_halted) begin
					s_nxt.st = ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		// halt overrides every other transition except the one out of ST_STOPPING
		if (task_go[0] && s_r.st != ST_STOPPING) begin
			s_nxt.st = ST_STOPPING;
			s_nxt.stop_p = 1'b1;
		end
		if (task_go[3]) begin
			s_nxt.armed_rx = 1'b1;
		end else if (eng_rx_started | stop_done) begin
			s_nxt.armed_rx = 1'b0;
		end
		if (task_go[4]) begin
			s_nxt.armed_tx = 1'b1;
		end else if (eng_tx_started | stop_done) begin
			s_nxt.armed_tx = 1'b0;
		end
		for (int i = 0; i < NT; i++) begin
			if (wr && a == sub_ofs(i)) begin
				s_nxt.sub[i].en = pwdata[`ROUTE_EN_BIT];
				s_nxt.sub[i].idx = pwdata[CHW-1:0];
			end
		end
		for (int i = 0; i < NE; i++) begin
			if (wr && a == pub_ofs(i)) begin
				s_nxt.pub[i].en = pwdata[`ROUTE_EN_BIT];
				s_nxt.pub[i].idx = pwdata[CHW-1:0];
			end
			if (wr && a == evt_ofs(i)) begin
				s_nxt.flag[i] = pwdata[`FLAG_BIT];
			end
			// hardware set wins over a software clear in the same cycle
			if (ev[i]) begin
				s_nxt.flag[i] = 1'b1;
			end
		end
		if (wr && a == `OFS_LINKS) begin
			s_nxt.link = {pwdata[`LINK_READ_BIT], pwdata[`LINK_WRITE_BIT]};
		end
		if (wr && a == `OFS_IEN) begin
			s_nxt.ien = ev_unpack(pwdata);
		end
		if (wr && a == `OFS_IEN_SET) begin
			s_nxt.ien = s_r.ien | ev_unpack(pwdata);
		end
		s_nxt.irq = |(s_nxt.flag & s_nxt.ien);
		rd = reg_read(a, s_r);
		s_nxt.pready = setup;
		s_nxt.pslverr = setup & ~rd[32];
		s_nxt.prdata = (setup & ~pwrite) ? rd[31:0] : `REG_RESET;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign chan_out = s_r.chan;
	assign stop_req = s_r.stop_p;
	assign bus_release = s_r.release_p;
	assign rx_armed = s_r.armed_rx;
	assign tx_armed = s_r.armed_tx;
	assign scl_hold = (s_r.st == ST_HELD);
	assign irq = s_r.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_arm_rx_go: assert property (wr && a == `OFS_ARM_RX_TASK && pwdata[`TASK_BIT] |=> rx_armed)
		else $error("receive arm task did not arm");
	a_arm_tx_go: assert property (wr && a == `OFS_ARM_TX_TASK && pwdata[`TASK_BIT] |=> tx_armed)
		else $error("transmit arm task did not arm");
	a_halt_sub_hit: assert property (s_r.sub[0].en && chan_in[s_r.sub[0].idx] && s_r.st != ST_STOPPING
		|=> stop_req ##1 !stop_req)
		else $error("subscribed halt did not pulse stop request");
	a_hold_sub_hit: assert property (s_r.sub[1].en && chan_in[s_r.sub[1].idx] && s_r.st == ST_ACTIVE && !task_go[0]
		|=> scl_hold)
		else $error("subscribed hold did not stretch");
	a_pub_fire: assert property (ev[4] && s_r.pub[4].en |=> chan_out[$past(s_r.pub[4].idx)])
		else $error("write event not broadcast");
	a_pub_quiet: assert property (!(|ev) |=> chan_out == '0)
		else $error("channel pulse without event");
	a_halted_flag: assert property (s_r.st == ST_STOPPING && eng_halted |=> s_r.flag[0] && bus_release
		&& s_r.st == ST_IDLE)
		else $error("halt completion not flagged");
	a_begun_flag: assert property (eng_rx_started && !task_go[3] |=> s_r.flag[2] && !rx_armed)
		else $error("receive begun not flagged");
	a_cmd_flag: assert property (eng_read |=> s_r.flag[5])
		else $error("read command not flagged");
	a_short_hold: assert property (s_r.link[1] && eng_read && s_r.st == ST_ACTIVE && !task_go[0]
		|=> scl_hold)
		else $error("read shortcut did not hold");
	a_ien_write: assert property (wr && a == `OFS_IEN |=> s_r.ien == ev_unpack($past(pwdata)))
		else $error("enable register not written");
	a_ien_set: assert property (wr && a == `OFS_IEN_SET
		|=> s_r.ien == ($past(s_r.ien) | ev_unpack($past(pwdata))))
		else $error("enable set wrong");
	a_hold_stays: assert property (scl_hold && !task_go[2] && !task_go[0] |=> scl_hold)
		else $error("hold released without continue");
	a_irq_gate: assert property (irq == |(s_r.flag & s_r.ien))
		else $error("interrupt does not match enabled flags");
endmodule

/* core/tws_cfg.svh */
// register map, field positions and reset values of the slave task/event layer
// assumes 12-bit word-aligned offsets inside the peripheral window
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH
`define OFS_HALT_TASK 12'h014
`define OFS_HOLD_TASK 12'h01C
`define OFS_CONT_TASK 12'h020
`define OFS_ARM_RX_TASK 12'h030
`define OFS_ARM_TX_TASK 12'h034
`define OFS_HALT_SUB 12'h094
`define OFS_HOLD_SUB 12'h09C
`define OFS_CONT_SUB 12'h0A0
`define OFS_ARM_RX_SUB 12'h0B0
`define OFS_ARM_TX_SUB 12'h0B4
`define OFS_HALTED_EVT 12'h104
`define OFS_FAULT_EVT 12'h124
`define OFS_RX_BEGUN_EVT 12'h14C
`define OFS_TX_BEGUN_EVT 12'h150
`define OFS_WRITE_EVT 12'h164
`define OFS_READ_EVT 12'h168
`define OFS_HALTED_PUB 12'h184
`define OFS_FAULT_PUB 12'h1A4
`define OFS_RX_BEGUN_PUB 12'h1CC
`define OFS_TX_BEGUN_PUB 12'h1D0
`define OFS_WRITE_PUB 12'h1E4
`define OFS_READ_PUB 12'h1E8
`define OFS_LINKS 12'h200
`define OFS_IEN 12'h300
`define OFS_IEN_SET 12'h304
`define ADDR_W 12
`define CHANNEL_INDEX_W 4
`define NUM_CH 16
`define NUM_TASK 5
`define NUM_EVT 6
`define TASK_BIT 0
`define FLAG_BIT 0
`define ROUTE_EN_BIT 31
`define LINK_WRITE_BIT 13
`define LINK_READ_BIT 14
`define IEN_HALTED_BIT 1
`define IEN_FAULT_BIT 9
`define IEN_RX_BEGUN_BIT 19
`define IEN_TX_BEGUN_BIT 20
`define IEN_WRITE_BIT 25
`define IEN_READ_BIT 26
`define REG_RESET 32'h00000000
`endif

/* core/tws_pkg.sv */
// types shared by the slave task/event layer
// assumes tws_cfg.svh is on the include path
package tws_pkg;
`include "tws_cfg.svh"
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_HELD = 2'b11,
		ST_STOPPING = 2'b10
	} ctrl_state_e;
	typedef struct packed {
		logic en;
		logic [`CHANNEL_INDEX_W-1:0] idx;
	} route_cfg_s;
endpackage

/* sim/bus_engine_model.sv */
// behavioural model of the two-wire bus engine that sits behind the task/event layer
// assumes cmd is a one-cycle request from the bench: 1 write, 2 read, 3 bus error
module bus_engine_model #(
	parameter int HDLY = 3
) (
	input wire logic pclk,
	input wire logic [1:0] cmd,
	input wire logic stop_req,
	input wire logic rx_armed,
	input wire logic tx_armed,
	input wire logic scl_hold,
	output logic eng_halted,
	output logic eng_error,
	output logic eng_rx_started,
	output logic eng_tx_started,
	output logic eng_write,
	output logic eng_read
);
	timeunit 1ns;
	timeprecision 1ps;
	// command latched at its request edge; the bench drops cmd after one cycle
	logic [1:0] c;
	initial begin
		{eng_halted, eng_error, eng_rx_started, eng_tx_started, eng_write, eng_read} = 6'h00;
	end
	always begin
		@(posedge pclk);
		{eng_halted, eng_error, eng_rx_started, eng_tx_started, eng_write, eng_read} <= 6'h00;
		if (stop_req) begin
			// halt answered only when no transfer was running; a stop request during a transfer is missed
			repeat (HDLY) @(posedge pclk);
			eng_halted <= 1'b1;
		end else if (cmd != 2'h0) begin
			c = cmd;
			eng_write <= (c == 2'h1);
			eng_read <= (c == 2'h2);
			eng_error <= (c == 2'h3);
			if (c != 2'h3) begin
				@(posedge pclk);
				{eng_write, eng_read} <= 2'h0;
				repeat (2) @(posedge pclk);
				// clock stretched: the transfer cannot start until released
				while (scl_hold) @(posedge pclk);
				eng_rx_started <= (c == 2'h1) & rx_armed;
				eng_tx_started <= (c == 2'h2) & tx_armed;
			end
		end
	end
endmodule

/* sim/tb_two_wire_slave_ctrl.sv */
// self-checking bench: apb register tasks plus engine model on the far side
// assumes the design answers each apb access and samples chan_in on pclk
module tb_two_wire_slave_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [15:0] chan_in, chan_out, seen;
	logic eng_halted, eng_error, eng_rx_started, eng_tx_started, eng_write, eng_read;
	logic stop_req, bus_release, rx_armed, tx_armed, scl_hold, irq;
	logic [1:0] cmd;
	logic [11:0] cfgs [11] = '{12'h094, 12'h09C, 12'h0A0, 12'h0B0, 12'h0B4, 12'h184, 12'h1A4,
		12'h1CC, 12'h1D0, 12'h1E4, 12'h1E8};
	int errors, tests_run, n;
	two_wire_slave_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chan_in(chan_in), .chan_out(chan_out),
		.eng_halted(eng_halted), .eng_error(eng_error), .eng_rx_started(eng_rx_started),
		.eng_tx_started(eng_tx_started), .eng_write(eng_write), .eng_read(eng_read),
		.stop_req(stop_req), .bus_release(bus_release), .rx_armed(rx_armed), .tx_armed(tx_armed),
		.scl_hold(scl_hold), .irq(irq));
	bus_engine_model u_eng (.pclk(pclk), .cmd(cmd), .stop_req(stop_req), .rx_armed(rx_armed),
		.tx_armed(tx_armed), .scl_hold(scl_hold), .eng_halted(eng_halted), .eng_error(eng_error),
		.eng_rx_started(eng_rx_started), .eng_tx_started(eng_tx_started), .eng_write(eng_write),
		.eng_read(eng_read));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) seen <= seen | chan_out;
	task automatic final_report();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one apb transfer; returns one idle edge after the access completes
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic chan(input logic [15:0] v);
		chan_in <= v;
		@(posedge pclk);
		chan_in <= 16'h0;
		@(posedge pclk);
	endtask
	task automatic eng(input logic [1:0] c);
		cmd <= c;
		@(posedge pclk);
		cmd <= 2'h0;
	endtask
	initial begin
		#100000ns;
		errors++;
		final_report();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{chan_in, cmd, seen, errors, tests_run} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(32'h200, 32'h0);
		rdchk(32'h300, 32'h0);
		for (int i = 0; i < 11; i++) begin
			rdchk({20'h0, cfgs[i]}, 32'h0);
			wr({20'h0, cfgs[i]}, 32'hFFFFFFFF);
			rdchk({20'h0, cfgs[i]}, 32'h8000000F);
			wr({20'h0, cfgs[i]}, 32'h0);
		end
		// unmapped offset answers with an error and no data
		apb(1'b0, 32'h308, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		wr(32'h300, 32'h06180202);
		rdchk(32'h300, 32'h06180202);
		wr(32'h300, 32'h0);
		wr(32'h304, 32'h00080000);
		wr(32'h304, 32'h0);
		rdchk(32'h304, 32'h00080000);
		rdchk(32'h300, 32'h00080000);
		// receive armed, begun event published on channel 5 and raising the interrupt
		wr(32'h1CC, 32'h80000005);
		wr(32'h030, 32'h1);
		chk({31'h0, rx_armed}, 32'h1);
		eng(2'h1);
		n = 0;
		while (rx_armed === 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
		rdchk(32'h14C, 32'h1);
		rdchk(32'h164, 32'h1);
		chk({16'h0, seen}, 32'h20);
		chk({31'h0, irq}, 32'h1);
		wr(32'h14C, 32'h0);
		wr(32'h164, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// transmit armed, publishing left disabled on channel 6
		wr(32'h1D0, 32'h00000006);
		wr(32'h034, 32'h1);
		chk({31'h0, tx_armed}, 32'h1);
		eng(2'h2);
		n = 0;
		while (tx_armed === 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
		rdchk(32'h150, 32'h1);
		rdchk(32'h168, 32'h1);
		chk({16'h0, seen}, 32'h20);
		// read shortcut holds the bus until continue arrives on channel 3
		wr(32'h200, 32'h00004000);
		wr(32'h0A0, 32'h80000003);
		wr(32'h034, 32'h1);
		eng(2'h2);
		n = 0;
		while (scl_hold !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, scl_hold}, 32'h1);
		repeat (5) @(posedge pclk);
		chk({31'h0, tx_armed}, 32'h1);
		chan(16'h0008);
		@(posedge pclk);
		chk({31'h0, scl_hold}, 32'h0);
		// arm from channel 1, then halt from channel 2
		wr(32'h0B0, 32'h80000001);
		chan(16'h0002);
		@(posedge pclk);
		chk({31'h0, rx_armed}, 32'h1);
		wr(32'h094, 32'h80000002);
		chan(16'h0004);
		chk({31'h0, stop_req}, 32'h1);
		n = 0;
		while (bus_release !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, bus_release}, 32'h1);
		@(posedge pclk);
		chk({31'h0, rx_armed}, 32'h0);
		rdchk(32'h104, 32'h1);
		eng(2'h3);
		repeat (3) @(posedge pclk);
		rdchk(32'h124, 32'h1);
		// hold from channel 9, published write command on channel 7, continue on channel 3
		wr(32'h1E4, 32'h80000007);
		wr(32'h09C, 32'h80000009);
		wr(32'h030, 32'h1);
		chan(16'h0200);
		chk({31'h0, scl_hold}, 32'h1);
		eng(2'h1);
		chan(16'h0008);
		repeat (4) @(posedge pclk);
		chk({16'h0, seen}, 32'hA0);
		chk({31'h0, rx_armed}, 32'h0);
		// reset in mid-run clears every register
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(32'h304, 32'h0);
		rdchk(32'h094, 32'h0);
		final_report();
	end
endmodule
